// >>> include/pwr_pkg.sv
// shared constants for the power mode and wake-up controller
package pwr_pkg;
    localparam logic [11:0] NORMAL_WAKE_CLKS = 12'hBB8; // 3000 low-speed periods
    localparam logic [11:0] FAST_WAKE_CLKS = 12'h02D; // 45 low-speed periods
    localparam logic [11:0] WAKE_CNT_ZERO = 12'h000;
    localparam int WAKE_CNT_W = 12;
    localparam int TIMER_CNT = 5;
    localparam int PIN_CNT = 8;
    localparam int CMP_EN_BIT = 7;
    localparam int CMP_WAKE_BIT = 6;
    localparam int WAKE_MODE_BIT = 5;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [2:0] LVR_LEVEL_DEFAULT = 3'h0;

    typedef enum logic [1:0] {
        PM_ON = 2'b00,
        PM_SAVE = 2'b01,
        PM_DOWN = 2'b10,
        PM_WAKE = 2'b11
    } pm_state_e;
endpackage

// >>> src/sync2.sv
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    // first stage only feeds the second
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

// >>> src/edge_det.sv
// rising edge detector for an already synchronised level
`timescale 1ns/100ps
module edge_det (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_level,
    output logic o_rise
);
    logic last_reg;

    // remembers the level so a one-cycle pulse marks a rise
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= i_level;
        end
    end

    assign o_rise = i_level & ~last_reg;
endmodule

// >>> src/power_mode_wakeup_ctrl.sv
// power mode, oscillator stop and wake-up delay control
// Overview of operation
// - run, power-save and power-down states
// - power-down stops oscillators; save keeps them
// - power-save gates only the system clock
// - low-speed oscillator stays on in save; resume from it
// - program memory off in save and down
// - outside run, timers stop if system-clocked or oscillator off
// - pin wake needs input mode and enable
// - non-system-clocked timer match wakes from save
// - comparator wake needs enable and select bits
// - power-down keeps data memory and registers
// - down wakes only by pin toggle
// - pin wake resumes after stop instruction
// - normal wake waits 3000 low-speed periods
// - fast wake waits 45 low-speed periods
// - fast boot option forces fast wake
// - any reset restores defaults, restarts at zero
// - pin or watchdog reset keeps data memory
// - low-voltage threshold from one-time option
// - low-speed oscillator off disables watchdog
`timescale 1ns/100ps
module power_mode_wakeup_ctrl
    import pwr_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_stop_exe,
    input wire logic i_stop_sys,
    input wire logic i_hrc_en,
    input wire logic i_lrc_en,
    input wire logic i_xtal_en,
    input wire logic i_wdt_en,
    input wire logic [7:0] i_comparator_control,
    input wire logic [7:0] i_comparator_select,
    input wire logic [7:0] i_misc,
    input wire logic i_fast_boot_opt,
    input wire logic [2:0] i_lvr_level_opt,
    input wire logic [PIN_CNT-1:0] i_pin,
    input wire logic [PIN_CNT-1:0] i_port_direction_bit,
    input wire logic [PIN_CNT-1:0] i_pin_dig_in_en,
    input wire logic [TIMER_CNT-1:0] i_timer_sysclk_src,
    input wire logic [TIMER_CNT-1:0] i_timer_osc_on,
    input wire logic [TIMER_CNT-1:0] i_timer_match,
    input wire logic i_comparator_out,
    input wire logic i_lrc_clk,
    input wire logic i_ext_reset_pin,
    input wire logic i_wdt_timeout,
    input wire logic i_por,
    output logic o_sys_clk_en,
    output logic o_cpu_run,
    output logic o_hrc_on,
    output logic o_lrc_on,
    output logic o_xtal_on,
    output logic o_otp_on,
    output logic o_wdt_on,
    output logic [TIMER_CNT-1:0] o_timer_run,
    output logic o_use_lrc_clk,
    output logic o_resume_pulse,
    output logic o_cpu_reset,
    output logic o_sram_clear_allowed,
    output logic [2:0] o_lvr_level,
    output logic [15:0] o_reset_vector,
    output logic [1:0] o_pm_state
);
    pm_state_e state_reg, state_next;
    logic [WAKE_CNT_W-1:0] wake_cnt_reg, wake_cnt_next;
    logic [PIN_CNT-1:0] pin_s;
    logic [2:0] misc_s;
    logic lrc_s, lrc_rise, cmp_s, ext_rst_s;
    logic pin_changed, pin_wake, timer_wake, cmp_wake, wake_ev;
    logic fast_mode;
    logic [WAKE_CNT_W-1:0] wake_target;
    logic [PIN_CNT-1:0] pin_last_reg;
    logic [PIN_CNT-1:0] wake_pin_mask;
    logic [TIMER_CNT-1:0] timer_can_run;
    logic from_down_reg;

    // pins, comparator and external reset arrive asynchronously
    sync2 #(.W(PIN_CNT)) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pin),
        .o_sync(pin_s)
    );

    sync2 #(.W(3)) u_misc_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_lrc_clk, i_comparator_out, i_ext_reset_pin}),
        .o_sync(misc_s)
    );

    assign lrc_s = misc_s[2];
    assign cmp_s = misc_s[1];
    assign ext_rst_s = misc_s[0];

    // low-speed clock is sampled; each rise is one wake-delay tick
    edge_det u_lrc_edge (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_level(lrc_s),
        .o_rise(lrc_rise)
    );

    // pin wake qualifies on input mode plus digital enable
    assign wake_pin_mask = i_port_direction_bit & i_pin_dig_in_en;
    assign pin_changed = |((pin_s ^ pin_last_reg) & wake_pin_mask);
    assign pin_wake = pin_changed;

    // outside run, timers stop when system-clocked or their oscillator is off
    assign timer_can_run = ~i_timer_sysclk_src & i_timer_osc_on;
    assign timer_wake = |(i_timer_match & ~i_timer_sysclk_src & i_timer_osc_on);

    // comparator wake needs both enable and wake select
    assign cmp_wake = cmp_s & i_comparator_control[CMP_EN_BIT]
        & i_comparator_select[CMP_WAKE_BIT];

    // down honours pin toggles only; save honours all three
    assign wake_ev = (state_reg == PM_DOWN) ? pin_wake
        : (state_reg == PM_SAVE) ? (pin_wake | timer_wake | cmp_wake) : 1'b0;

    // the fuse option overrides the software mode bit
    assign fast_mode = i_fast_boot_opt | i_misc[WAKE_MODE_BIT];
    assign wake_target = fast_mode ? FAST_WAKE_CLKS : NORMAL_WAKE_CLKS;

    // pin history, kept across power-down so a toggle is seen
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pin_last_reg <= '0;
        end else begin
            pin_last_reg <= pin_s;
        end
    end

    // mode sequencing; the delay counter clears on wake entry and otherwise only moves on low-speed ticks
    always_comb begin
        state_next = state_reg;
        wake_cnt_next = wake_cnt_reg;
        case (state_reg)
            PM_ON: begin
                if (i_stop_sys) begin
                    state_next = PM_DOWN;
                end else if (i_stop_exe) begin
                    state_next = PM_SAVE;
                end
            end
            PM_SAVE, PM_DOWN: begin
                if (wake_ev) begin
                    state_next = PM_WAKE;
                    wake_cnt_next = WAKE_CNT_ZERO;
                end
            end
            PM_WAKE: begin
                if (lrc_rise) begin
                    wake_cnt_next = wake_cnt_reg + 12'h001;
                    if (wake_cnt_reg + 12'h001 >= wake_target) begin
                        state_next = PM_ON;
                    end
                end
            end
            default: begin
                state_next = PM_ON;
            end
        endcase
    end

    // sequencer registers; reset returns to run
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state_reg <= PM_ON;
            wake_cnt_reg <= WAKE_CNT_ZERO;
        end else begin
            state_reg <= state_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

    // remembers a wake that began in power-down, so the high-speed
    // oscillator stays off for the whole delay, not just its first cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            from_down_reg <= 1'b0;
        end else if (state_reg == PM_DOWN && state_next == PM_WAKE) begin
            from_down_reg <= 1'b1;
        end else if (state_next == PM_ON) begin
            from_down_reg <= 1'b0;
        end
    end

    // derived controls, registered so every output is a flip-flop
    logic in_save_next, in_down_next, stopped_next;
    assign in_save_next = (state_next == PM_SAVE);
    assign in_down_next = (state_next == PM_DOWN);
    assign stopped_next = (state_next != PM_ON);

    // reset request: power-on, pin or watchdog; only power-on may clear data
    logic rst_req;
    assign rst_req = i_por | ext_rst_s | i_wdt_timeout;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_sys_clk_en <= 1'b1;
            o_cpu_run <= 1'b1;
            o_hrc_on <= 1'b1;
            o_lrc_on <= 1'b1;
            o_xtal_on <= 1'b0;
            o_otp_on <= 1'b1;
            o_wdt_on <= 1'b1;
            o_timer_run <= '0;
            o_use_lrc_clk <= 1'b0;
            o_resume_pulse <= 1'b0;
            o_cpu_reset <= 1'b0;
            o_sram_clear_allowed <= 1'b0;
            o_lvr_level <= LVR_LEVEL_DEFAULT;
            o_reset_vector <= RESET_VECTOR;
            o_pm_state <= PM_ON;
        end else begin
            // only the system clock is gated; cpu resumes in place
            o_sys_clk_en <= ~stopped_next;
            o_cpu_run <= ~stopped_next;
            // save keeps high-speed and crystal as software left them; down stops all
            o_hrc_on <= i_hrc_en & ~in_down_next
                & ~(state_next == PM_WAKE & (state_reg == PM_DOWN | from_down_reg));
            o_xtal_on <= i_xtal_en & ~in_down_next;
            // low-speed stays on in save and restarts first when waking
            o_lrc_on <= ~in_down_next & (i_lrc_en | in_save_next | (state_next == PM_WAKE));
            o_use_lrc_clk <= (state_next == PM_WAKE);
            o_otp_on <= ~(in_save_next | in_down_next);
            // watchdog dies with its clock source
            o_wdt_on <= i_wdt_en & i_lrc_en & ~in_down_next;
            // in run, timers follow their own clocks; in save and wake, only off-sysclk ones; in down, none
            o_timer_run <= stopped_next ? (timer_can_run & {TIMER_CNT{~in_down_next}})
                : i_timer_osc_on;
            o_resume_pulse <= (state_reg == PM_WAKE) & (state_next == PM_ON);
            o_cpu_reset <= rst_req;
            // data memory is never cleared by hardware on pin or watchdog reset
            o_sram_clear_allowed <= i_por & ~ext_rst_s & ~i_wdt_timeout;
            o_lvr_level <= i_lvr_level_opt;
            o_reset_vector <= RESET_VECTOR;
            o_pm_state <= state_next;
        end
    end
endmodule

// >>> tb/pwr_ctrl_assertions.sv
// concurrent checks on the power mode controller ports
`timescale 1ns/100ps
module pwr_ctrl_checker
    import pwr_pkg::*;
(
    input logic i_sys_clk,
    input logic i_rst_b,
    input logic i_stop_exe,
    input logic i_stop_sys,
    input logic [TIMER_CNT-1:0] i_timer_sysclk_src,
    input logic [TIMER_CNT-1:0] i_timer_osc_on,
    input logic o_sys_clk_en,
    input logic o_cpu_run,
    input logic o_hrc_on,
    input logic o_lrc_on,
    input logic o_xtal_on,
    input logic o_otp_on,
    input logic o_wdt_on,
    input logic [TIMER_CNT-1:0] o_timer_run,
    input logic o_resume_pulse,
    input logic [1:0] o_pm_state
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // stop requests count only from the running state; power-down wins a tie
    sequence s_stop_exe; o_pm_state == PM_ON && i_stop_exe && !i_stop_sys; endsequence
    sequence s_stop_sys; o_pm_state == PM_ON && i_stop_sys; endsequence
    sequence s_left_wake; $past(o_pm_state) == PM_WAKE && o_pm_state == PM_ON; endsequence
    sequence s_held_save; o_pm_state == PM_SAVE && $past(o_pm_state) == PM_SAVE; endsequence
    property p_enter_save; s_stop_exe |=> o_pm_state == PM_SAVE && !o_sys_clk_en; endproperty
    a_enter_save: assert property (p_enter_save) else $error("save not entered");
    property p_enter_down; s_stop_sys |=> o_pm_state == PM_DOWN; endproperty
    a_enter_down: assert property (p_enter_down) else $error("down not entered");
    property p_save_gate; o_pm_state == PM_SAVE |-> !o_sys_clk_en && !o_cpu_run; endproperty
    a_save_gate: assert property (p_save_gate) else $error("clock not gated");
    property p_otp_off; o_pm_state inside {PM_SAVE, PM_DOWN} |-> !o_otp_on; endproperty
    a_otp_off: assert property (p_otp_off) else $error("program memory on");
    property p_down_osc;
        o_pm_state == PM_DOWN |-> !(o_hrc_on || o_lrc_on || o_xtal_on) && o_timer_run == '0;
    endproperty
    a_down_osc: assert property (p_down_osc) else $error("oscillator on in down");
    property p_save_osc; s_held_save |-> $stable(o_hrc_on) && $stable(o_xtal_on); endproperty
    a_save_osc: assert property (p_save_osc) else $error("oscillator changed");
    property p_lrc_held; o_pm_state inside {PM_SAVE, PM_WAKE} |-> o_lrc_on; endproperty
    a_lrc_held: assert property (p_lrc_held) else $error("low-speed osc off");
    property p_save_timers;
        s_held_save |-> o_timer_run == $past(i_timer_osc_on & ~i_timer_sysclk_src);
    endproperty
    a_save_timers: assert property (p_save_timers) else $error("timer run wrong");
    property p_resume; o_resume_pulse |-> s_left_wake ##0 o_cpu_run; endproperty
    a_resume: assert property (p_resume) else $error("bad resume");
    property p_wdt_lrc; o_wdt_on |-> o_lrc_on; endproperty
    a_wdt_lrc: assert property (p_wdt_lrc) else $error("watchdog without osc");
endmodule
bind power_mode_wakeup_ctrl pwr_ctrl_checker u_chk (.*);

// >>> tb/wake_src_model.sv
// wake-up source model: low-speed oscillator and input pins
`timescale 1ns/100ps
module wake_src_model (
    input wire logic i_sys_clk,
    input wire logic i_lrc_on,
    input wire logic [7:0] i_flip,
    output logic o_lrc_clk,
    output logic [7:0] o_pin
);
    // oscillator stands still low while the device holds it off
    initial begin
        o_lrc_clk = 1'b0;
        forever #100 o_lrc_clk = i_lrc_on ? ~o_lrc_clk : 1'b0;
    end
    // pins are driven inputs, toggled on request
    initial o_pin = 8'h00;
    always @(posedge i_sys_clk) o_pin <= o_pin ^ i_flip;
endmodule

// >>> tb/power_mode_wakeup_ctrl_tb_top.sv
// self-checking bench for the power mode and wake-up controller
`timescale 1ns/100ps
module power_mode_wakeup_ctrl_tb_top import pwr_pkg::*;;
    logic i_sys_clk, i_rst_b, i_stop_exe, i_stop_sys, i_hrc_en, i_lrc_en, i_xtal_en, i_wdt_en;
    logic i_fast_boot_opt, i_comparator_out, i_lrc_clk, i_ext_reset_pin, i_wdt_timeout, i_por;
    logic [7:0] i_comparator_control, i_comparator_select, i_misc, i_pin, flip;
    logic [7:0] i_port_direction_bit, i_pin_dig_in_en;
    logic [2:0] i_lvr_level_opt, o_lvr_level;
    logic [4:0] i_timer_sysclk_src, i_timer_osc_on, i_timer_match, o_timer_run;
    logic o_sys_clk_en, o_cpu_run, o_hrc_on, o_lrc_on, o_xtal_on, o_otp_on, o_wdt_on;
    logic o_use_lrc_clk, o_resume_pulse, o_cpu_reset, o_sram_clear_allowed;
    logic [15:0] o_reset_vector;
    logic [1:0] o_pm_state;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    power_mode_wakeup_ctrl dut (.*);
    wake_src_model src (.i_sys_clk(i_sys_clk), .i_lrc_on(o_lrc_on), .i_flip(flip),
        .o_lrc_clk(i_lrc_clk), .o_pin(i_pin));
    // 50 MHz system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    // inputs move 1 ns after the edge so sampling never races
    task automatic step(input int n); repeat (n) @(posedge i_sys_clk); #1; endtask
    // wide enough that the reset check keeps its flag bits beside the vector
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int s);
        num_checks++;
        if (s < lo || s > hi) begin
            err_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic stop_req(input logic down);
        if (down) i_stop_sys = 1'b1;
        else i_stop_exe = 1'b1;
        step(1);
        {i_stop_sys, i_stop_exe} = 2'b00;
    endtask
    task automatic flip_pin(input logic [7:0] m); flip = m; step(1); flip = 8'h00; endtask
    // counts low-speed rises from wake entry to resume; edges are sampled off the clock edge
    task automatic wake_time(input int n);
        int k, r;
        logic p;
        k = 0;
        r = 0;
        while (o_pm_state !== PM_WAKE && k < 50) begin step(1); k++; end
        chk("wake_state", PM_WAKE, o_pm_state);
        chk("use_lrc", 16'h1, o_use_lrc_clk);
        p = i_lrc_clk;
        while (o_resume_pulse !== 1'b1 && k < 40000) begin
            step(1);
            r += (i_lrc_clk && !p);
            p = i_lrc_clk;
            k++;
        end
        chk_rng("wake_ticks", n - 1, n + 1, r);
        chk("resume", {PM_ON, 2'b11}, {o_pm_state, o_cpu_run, o_sys_clk_en});
    endtask
    task automatic t_save_pin();
        {i_misc, i_port_direction_bit, i_pin_dig_in_en} = {8'h20, 8'h03, 8'h01};
        stop_req(1'b0);
        chk("save", {PM_SAVE, 4'h1}, {o_pm_state, o_sys_clk_en, o_cpu_run, o_otp_on, o_hrc_on});
        step(1);
        chk("timer_run", 16'h1E, o_timer_run);
        i_timer_match = 5'h01;
        step(2);
        i_timer_match = 5'h00;
        flip_pin(8'h02);
        step(8);
        chk("no_wake", PM_SAVE, o_pm_state);
        flip_pin(8'h01);
        wake_time(45);
    endtask
    task automatic t_timer_cmp();
        {i_misc, i_fast_boot_opt} = {8'h00, 1'b1};
        stop_req(1'b0);
        i_timer_match = 5'h04;
        step(2);
        i_timer_match = 5'h00;
        wake_time(45);
        i_comparator_control = 8'h80;
        stop_req(1'b0);
        i_comparator_out = 1'b1;
        step(8);
        chk("cmp_unsel", PM_SAVE, o_pm_state);
        i_comparator_select = 8'h40;
        i_comparator_out = 1'b0;
        step(4);
        i_comparator_out = 1'b1;
        wake_time(45);
    endtask
    task automatic t_down();
        {i_fast_boot_opt, i_comparator_control} = {1'b0, 8'h00};
        stop_req(1'b1);
        chk("down", {PM_DOWN, 3'h0}, {o_pm_state, o_hrc_on, o_lrc_on, o_xtal_on});
        i_timer_match = 5'h1F;
        step(2);
        i_timer_match = 5'h00;
        step(8);
        chk("down_hold", PM_DOWN, o_pm_state);
        flip_pin(8'h01);
        wake_time(3000);
    endtask
    task automatic t_resets();
        chk("lvr", 16'h5, o_lvr_level);
        i_lrc_en = 1'b0;
        step(2);
        chk("wdt_off", 16'h0, o_wdt_on);
        {i_lrc_en, i_wdt_timeout} = 2'b11;
        step(2);
        chk("wdt_rst", {2'b10, RESET_VECTOR}, {o_cpu_reset, o_sram_clear_allowed, o_reset_vector});
        {i_wdt_timeout, i_por} = 2'b01;
        step(2);
        chk("por", 16'h3, {o_cpu_reset, o_sram_clear_allowed});
        i_por = 1'b0;
        step(4);
        chk("restart", PM_ON, o_pm_state);
    endtask
    // a hang is cut short well beyond the longest normal wake
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        {i_rst_b, i_stop_exe, i_stop_sys, i_fast_boot_opt, i_comparator_out} = 5'h00;
        {i_ext_reset_pin, i_wdt_timeout, i_por, i_timer_match, i_timer_sysclk_src} = 13'h001;
        {i_comparator_control, i_comparator_select, i_misc, flip} = 32'h0;
        {i_port_direction_bit, i_pin_dig_in_en, i_timer_osc_on} = 21'h1F;
        {i_hrc_en, i_lrc_en, i_xtal_en, i_wdt_en, i_lvr_level_opt} = 7'h7D;
        step(16);
        i_rst_b = 1'b1;
        step(3);
        chk("reset", {PM_ON, 2'b11}, {o_pm_state, o_cpu_run, o_sys_clk_en});
        t_save_pin();
        t_timer_cmp();
        t_down();
        t_resets();
        end_sim();
    end
endmodule
